// [ccdtg_gen.sv]
// CCD timing generator: transfer, vertical, horizontal and shutter pulses
`timescale 1ns/1ps
`default_nettype none
module ccdtg_gen #(
	parameter int unsigned LINES = 484,
	parameter int unsigned PIXELS = 648,
	parameter int unsigned SHUT_CYCLES = ccdtg_pkg::SHUT_CYC,
	parameter int unsigned EXPO_MIN_CYCLES = ccdtg_pkg::EXPO_MIN_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_start,
	input wire logic i_dual_mode,
	input wire logic i_shutter_en,
	input wire logic [ccdtg_pkg::CNT_W-1:0] i_shutter_line,
	// Sensor drive
	output logic o_transfer_pulse,
	output logic o_vertical_shift_phase_one,
	output logic o_vertical_shift_phase_two,
	output logic o_register_a_to_b,
	output logic o_horizontal_a_first_phase,
	output logic o_horizontal_b_first_phase,
	output logic o_horizontal_second_phase,
	output logic o_reset_pulse,
	output logic o_clamp,
	output logic o_sample,
	output logic o_substrate_shutter,
	// Status
	output logic o_busy,
	output logic o_frame_done
);
	import ccdtg_pkg::*;

	typedef struct packed {
		ccdtg_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] line;
		logic [CNT_W-1:0] pix;
		logic shut_pend;
		logic dual;
		logic xfer;
		logic v1;
		logic v2;
		logic ab;
		logic h1;
		logic rst_p;
		logic clamp;
		logic samp;
		logic sub;
		logic done;
		logic h1b;
		logic h2;
		logic busy;
		logic go;
		logic expo_run;
		logic [CNT_W-1:0] expo;
	} ccdtg_regs_t;

	ccdtg_regs_t s_q;
	ccdtg_regs_t s_d;

	function automatic logic last(input logic [CNT_W-1:0] c,
		input int unsigned n);
		last = (c == CNT_W'(n - 1));
	endfunction : last

	always_comb
	begin
		s_d = s_q;
		s_d.cnt = s_q.cnt + 1'b1;
		s_d.done = 1'b0;
		s_d.rst_p = 1'b0;
		s_d.clamp = 1'b0;
		s_d.samp = 1'b0;
		// Saturates so that a long idle gap never wraps
		if (s_q.expo_run && !last(s_q.expo, EXPO_MIN_CYCLES))
			s_d.expo = s_q.expo + 1'b1;
		case (s_q.st)
			CCDTG_IDLE:
			begin
				s_d.cnt = '0;
				if (i_start)
					s_d.go = 1'b1;
				// Early start waits here rather than cut the exposure short
				if ((i_start || s_q.go) && (!s_q.expo_run ||
					last(s_q.expo, EXPO_MIN_CYCLES)))
				begin
					s_d.st = CCDTG_XFER;
					s_d.go = 1'b0;
					s_d.expo_run = 1'b0;
					s_d.dual = i_dual_mode;
					s_d.xfer = 1'b1;
					s_d.line = '0;
				end
			end
			CCDTG_XFER:
			if (last(s_q.cnt, XFER_CYC))
			begin
				s_d.xfer = 1'b0;
				s_d.st = CCDTG_VSH1;
				s_d.cnt = '0;
				s_d.v1 = 1'b1;
				s_d.shut_pend = i_shutter_en;
			end
			CCDTG_VSH1:
			if (last(s_q.cnt, VPH_CYC))
			begin
				s_d.v1 = 1'b0;
				s_d.v2 = 1'b1;
				s_d.st = CCDTG_VSH2;
				s_d.cnt = '0;
			end
			CCDTG_VSH2:
			if (last(s_q.cnt, VPH_CYC))
			begin
				s_d.v2 = 1'b0;
				s_d.cnt = '0;
				s_d.pix = '0;
				if (s_q.dual)
				begin
					s_d.ab = 1'b1;
					s_d.st = CCDTG_AB;
				end
				else if (s_q.shut_pend && s_q.line == i_shutter_line)
				begin
					s_d.sub = 1'b1;
					s_d.st = CCDTG_SHUT;
				end
				else
					s_d.st = CCDTG_HORZ;
			end
			CCDTG_AB:
			if (last(s_q.cnt, AB_CYC))
			begin
				s_d.ab = 1'b0;
				s_d.cnt = '0;
				if (s_q.shut_pend && s_q.line == i_shutter_line)
				begin
					s_d.sub = 1'b1;
					s_d.st = CCDTG_SHUT;
				end
				else
					s_d.st = CCDTG_HORZ;
			end
			CCDTG_SHUT:
			if (last(s_q.cnt, SHUT_CYCLES))
			begin
				s_d.sub = 1'b0;
				s_d.shut_pend = 1'b0;
				s_d.expo_run = 1'b1;
				s_d.expo = '0;
				s_d.st = CCDTG_WAIT;
				s_d.cnt = '0;
			end
			CCDTG_WAIT:
			if (last(s_q.cnt, POST_SHUT_CYC))
			begin
				s_d.st = CCDTG_HORZ;
				s_d.cnt = '0;
			end
			CCDTG_HORZ:
			begin
				// Pixel period is two half cycles of HHALF_CYC each
				if (last(s_q.cnt, HHALF_CYC))
				begin
					s_d.cnt = '0;
					s_d.h1 = ~s_q.h1;
					if (s_q.h1)
					begin
						s_d.pix = s_q.pix + 1'b1;
						if (last(s_q.pix, PIXELS))
						begin
							s_d.pix = '0;
							s_d.line = s_q.line + 1'b1;
							s_d.st = CCDTG_VSH1;
							s_d.v1 = 1'b1;
							if (last(s_q.line, LINES))
							begin
								s_d.st = CCDTG_IDLE;
								s_d.v1 = 1'b0;
								s_d.done = 1'b1;
							end
						end
					end
				end
				// Reset, clamp, then sample closing the pixel; last one kept
				s_d.rst_p = ~s_q.h1 && s_q.cnt == '0;
				s_d.clamp = s_q.h1 && s_q.cnt == '0;
				s_d.samp = s_q.h1 && last(s_q.cnt, HHALF_CYC);
			end
			default:
				s_d.st = CCDTG_IDLE;
		endcase
		// Derived pins registered so every output leaves a flop
		s_d.h1b = s_d.h1 && s_d.dual;
		s_d.h2 = !s_d.h1 && (s_d.st == CCDTG_HORZ);
		s_d.busy = (s_d.st != CCDTG_IDLE) || s_d.go;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign o_transfer_pulse = s_q.xfer;
	assign o_vertical_shift_phase_one = s_q.v1;
	assign o_vertical_shift_phase_two = s_q.v2;
	assign o_register_a_to_b = s_q.ab;
	assign o_horizontal_a_first_phase = s_q.h1;
	assign o_horizontal_b_first_phase = s_q.h1b;
	assign o_horizontal_second_phase = s_q.h2;
	assign o_reset_pulse = s_q.rst_p;
	assign o_clamp = s_q.clamp;
	assign o_sample = s_q.samp;
	assign o_substrate_shutter = s_q.sub;
	assign o_busy = s_q.busy;
	assign o_frame_done = s_q.done;

	chk_shut_width: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(s_q.sub) |-> $past(s_q.cnt) >=
		CNT_W'(SHUT_MIN_NS * CLK_MHZ / 1000 - 1))
		else $error("shutter pulse too short");
	chk_xfer_width: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(s_q.xfer) |-> s_q.xfer [*8] ##0 (s_q.cnt < CNT_W'(XFER_CYC)))
		else $error("transfer pulse broken");
	chk_xfer_len: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(s_q.xfer) |-> $past(s_q.cnt) == CNT_W'(XFER_CYC - 1))
		else $error("transfer pulse wrong length");
	chk_vph_len: assert property (@(posedge i_clk) disable iff (i_rst)
		($fell(s_q.v1) || $fell(s_q.v2)) |-> $past(s_q.cnt) == CNT_W'(VPH_CYC - 1))
		else $error("vertical phase wrong length");
	chk_ab_len: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(s_q.ab) |-> $past(s_q.cnt) == CNT_W'(AB_CYC - 1) && s_q.dual)
		else $error("a to b pulse wrong");
	chk_post_shut: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(s_q.sub) |-> !s_q.h1 [*8])
		else $error("horizontal clock too soon after shutter");
	chk_b_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
		!s_q.dual |-> !o_horizontal_b_first_phase)
		else $error("b phase toggled in single mode");
	chk_sub_place: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.sub |-> s_q.st == CCDTG_SHUT && !s_q.h1 && !s_q.v1)
		else $error("substrate pulsed outside shutter");
	chk_h_rate: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(s_q.h1) |=> $stable(s_q.h1))
		else $error("horizontal clock too fast");
	chk_rst_first: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.rst_p |=> !s_q.rst_p ##1 s_q.clamp)
		else $error("reset pulse order wrong");
	chk_samp_after: assert property (@(posedge i_clk) disable iff (i_rst)
		s_q.clamp |=> s_q.samp)
		else $error("sample missing after clamp");
	chk_expo_min: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(s_q.xfer) |-> !$past(s_q.expo_run) ||
		$past(s_q.expo) == CNT_W'(EXPO_MIN_CYCLES - 1))
		else $error("exposure shorter than minimum");
	cov_hold: cover property (@(posedge i_clk) s_q.go ##1 s_q.go);
	cov_dual: cover property (@(posedge i_clk) $fell(s_q.ab));
	cov_shut: cover property (@(posedge i_clk) $fell(s_q.sub));
	cov_frame: cover property (@(posedge i_clk) s_q.done);
endmodule : ccdtg_gen
`default_nettype wire

// [ccdtg_pkg.sv]
// Package of timing constants for the CCD timing generator
package ccdtg_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned SHUT_MIN_NS = 10000;
	localparam int unsigned SHUT_NOM_NS = 25000;
	localparam int unsigned XFER_MIN_NS = 4000;
	localparam int unsigned XFER_NOM_NS = 5000;
	localparam int unsigned VPH_MIN_NS = 2000;
	localparam int unsigned VPH_NOM_NS = 2500;
	localparam int unsigned AB_MIN_NS = 2000;
	localparam int unsigned AB_NOM_NS = 2500;
	localparam int unsigned POST_SHUT_NS = 1000;
	localparam int unsigned EXPO_MIN_NS = 100000;
	localparam int unsigned RST_PULSE_NS = 10;
	localparam int unsigned HMAX_MHZ = 30;
	localparam int unsigned SHUT_CYC = SHUT_NOM_NS * CLK_MHZ / 1000;
	localparam int unsigned XFER_CYC = XFER_NOM_NS * CLK_MHZ / 1000;
	localparam int unsigned VPH_CYC = VPH_NOM_NS * CLK_MHZ / 1000;
	localparam int unsigned AB_CYC = AB_NOM_NS * CLK_MHZ / 1000;
	localparam int unsigned POST_SHUT_CYC = (POST_SHUT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned EXPO_MIN_CYC = (EXPO_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	// Half period of 2 cycles keeps the pixel clock at 25 MHz
	localparam int unsigned HHALF_CYC =
		(CLK_MHZ + 2 * HMAX_MHZ - 1) / (2 * HMAX_MHZ);
	localparam int unsigned CNT_W = 24;
	typedef enum logic [2:0] {
		CCDTG_IDLE = 3'b000,
		CCDTG_XFER = 3'b001,
		CCDTG_VSH1 = 3'b011,
		CCDTG_VSH2 = 3'b010,
		CCDTG_AB = 3'b110,
		CCDTG_HORZ = 3'b111,
		CCDTG_SHUT = 3'b101,
		CCDTG_WAIT = 3'b100
	} ccdtg_state_t;
endpackage : ccdtg_pkg

// [ccdtg_sensor_model.sv]
// Behavioural model of the sensor side of the timing generator
`timescale 1ns/1ps
`default_nettype none
module ccdtg_sensor_model (
	// Drive from the controller
	input wire logic i_transfer,
	input wire logic i_shutter,
	// Sensor state seen by the bench
	output logic o_antiblooming_off,
	output logic o_photo_clear
);
	// Antiblooming is off for exactly the transfer pulse
	assign o_antiblooming_off = i_transfer;
	// Shutter empties the photodiodes, restarting exposure
	assign o_photo_clear = i_shutter;
endmodule : ccdtg_sensor_model
`default_nettype wire

// [ccdtg_gen_tb_top.sv]
// Self-checking testbench for the CCD timing generator
`timescale 1ns/1ps
`default_nettype none
module ccdtg_gen_tb_top;
	import ccdtg_pkg::*;
	localparam int LN = 2;
	localparam int PX = 4;
	logic i_clk, i_rst, i_start, i_dual_mode, i_shutter_en;
	logic [CNT_W-1:0] i_shutter_line;
	logic xf, v1, v2, ab, h1a, h1b, h2, rp, clp, smp, sh, busy, done;
	logic abo, clr, pa, prp;
	logic [4:0] pv, cv;
	int n_fail = 0;
	int checks_done = 0;
	int seed = 32'h32D2;
	int q[$];
	int w = 0;
	int hw = 0;
	int gap = -1;
	int ns = 0;
	int nh = 0;
	int ex = -1;
	logic pc;
	ccdtg_gen #(.LINES(LN), .PIXELS(PX)) i_dut (.i_clk(i_clk),
		.i_rst(i_rst), .i_start(i_start), .i_dual_mode(i_dual_mode),
		.i_shutter_en(i_shutter_en), .i_shutter_line(i_shutter_line),
		.o_transfer_pulse(xf), .o_vertical_shift_phase_one(v1),
		.o_vertical_shift_phase_two(v2), .o_register_a_to_b(ab),
		.o_horizontal_a_first_phase(h1a),
		.o_horizontal_b_first_phase(h1b),
		.o_horizontal_second_phase(h2), .o_reset_pulse(rp),
		.o_clamp(clp), .o_sample(smp), .o_substrate_shutter(sh),
		.o_busy(busy), .o_frame_done(done));
	ccdtg_sensor_model i_model (.i_transfer(xf), .i_shutter(sh),
		.o_antiblooming_off(abo), .o_photo_clear(clr));
	initial
	begin
		i_clk = 0;
		forever #5 i_clk = ~i_clk;
	end
	task automatic chk(input string nm, input int e, input int s);
		checks_done++;
		if (e != s)
		begin
			n_fail++;
			$display("Error %s expected %0d seen %0d", nm, e, s);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	// Expected pulse widths in order, 0 marks frame end
	task automatic frame(input logic d, input logic se, input int sl);
		int k;
		q.push_back(XFER_CYC);
		for (int l = 0; l < LN; l++)
		begin
			q.push_back(VPH_CYC);
			q.push_back(VPH_CYC);
			if (d)
				q.push_back(AB_CYC);
			if (se && l == sl)
				q.push_back(SHUT_CYC);
		end
		q.push_back(0);
		@(posedge i_clk);
		i_dual_mode <= d;
		i_shutter_en <= se;
		i_shutter_line <= CNT_W'(sl);
		i_start <= 1;
		@(posedge i_clk);
		i_start <= 0;
		// Second start mid-frame must be ignored
		repeat (20) @(posedge i_clk);
		i_start <= 1;
		@(posedge i_clk);
		i_start <= 0;
		for (k = 0; k < 20000 && busy !== 1'b0; k++)
			@(posedge i_clk);
		if (k == 20000)
		begin
			chk("frame timeout", 0, 1);
			results();
		end
		repeat (600) @(posedge i_clk);
		chk("pending pulses", 0, q.size());
	endtask : frame
	function automatic int pop();
		return q.size() ? q.pop_front() : -1;
	endfunction : pop
	always @(posedge i_clk)
	begin
		cv = {xf, v1, v2, ab, sh};
		if (i_rst)
			w = 0;
		else
		begin
			if (cv != pv && pv != 0)
			begin
				chk("pulse width", pop(), w);
				w = 0;
			end
			if (cv != 0)
				w++;
			if (smp === 1'b1)
				ns++;
			if (h2 === 1'b1)
				nh++;
			if (done === 1'b1)
			begin
				chk("frame end", pop(), 0);
				chk("samples", LN * PX, ns);
				chk("h2 cycles", LN * PX * int'(HHALF_CYC), nh);
				ns = 0;
				nh = 0;
			end
			if (pv[0] && !sh)
				gap = 0;
			else if (gap >= 0)
				gap++;
			if (gap >= 0 && h2 === 1'b1)
			begin
				chk("shutter gap", 1, int'(gap >= POST_SHUT_CYC));
				gap = -1;
			end
			if (pc && clr !== 1'b1)
				ex = 0;
			else if (ex >= 0)
				ex++;
			if (xf === 1'b1 && !pv[4] && ex >= 0)
			begin
				chk("exposure", 1, int'(ex >= EXPO_MIN_CYC));
				ex = -1;
			end
			hw++;
			if (h1a !== pa)
			begin
				chk("h1 half period", 1, int'(hw >= HHALF_CYC));
				hw = 0;
			end
			chk("h2 overlap", 0, int'(h2 === 1'b1 && h1a === 1'b1));
			if (!i_dual_mode)
				chk("h1b single", 0, int'(h1b !== 1'b0));
			chk("antiblooming", 1, int'(abo === xf));
			if (rp === 1'b1)
				prp = 1;
			if (clp === 1'b1)
			begin
				chk("reset before clamp", 1, int'(prp === 1'b1));
				prp = 0;
			end
		end
		pv = cv;
		pa = h1a;
		pc = clr;
	end
	initial
	begin
		pv = 0;
		pa = 0;
		prp = 0;
		pc = 0;
		i_rst = 1;
		i_start = 0;
		i_dual_mode = 0;
		i_shutter_en = 0;
		i_shutter_line = '0;
		repeat (4) @(posedge i_clk);
		i_rst <= 0;
		frame(0, 1, 0);
		frame(1, 0, 0);
		frame(1, 1, LN - 1);
		repeat (3)
			frame(1'($random(seed)), 1'($random(seed)),
				int'($unsigned($random(seed)) % LN));
		results();
	end
endmodule : ccdtg_gen_tb_top
`default_nettype wire
